// [bench/ctm_checker.sv]
// port assertions for the transceiver mode controller
`default_nettype none
module ctm_checker (
	input wire logic                     CLK,
	input wire logic                     RSTN,
	input wire ctm_pkg::ctm_chip_mode_t  CHIP_MODE_CONTROL,
	input wire logic [1:0]               TRANSCEIVER_MODE_SELECT,
	input wire logic                     SUPPLY_BELOW_90,
	input wire logic                     BATTERY_UV,
	input wire logic                     TXD_IN,
	input wire logic                     TX_DRIVE_DOMINANT,
	input wire logic                     RXD_OUT,
	input wire logic [1:0]               BUS_BIAS,
	input wire logic                     TRANSCEIVER_ACTIVE,
	input wire logic                     BUS_WAKE_EVENT,
	input wire logic                     SUPPLY_ENABLE_REQ,
	input wire logic                     CHIP_WAKE_REQ,
	input wire ctm_pkg::ctm_xcvr_state_t XCVR_STATE
);
	import ctm_pkg::*;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence s_on;
		XCVR_STATE != XS_OFF && !BATTERY_UV && CHIP_MODE_CONTROL == CHIP_NORMAL;
	endsequence
	sequence s_req_pulse;
		CHIP_WAKE_REQ && SUPPLY_ENABLE_REQ && BUS_WAKE_EVENT ##1 !CHIP_WAKE_REQ;
	endsequence
	a_flag_matches: assert property (TRANSCEIVER_ACTIVE == (XCVR_STATE == XS_ACTIVE))
		else $error("active flag disagrees with state");
	a_online_mid: assert property (XCVR_STATE inside {XS_LISTEN, XS_ACTIVE} |-> BUS_BIAS == BIAS_MID)
		else $error("online state without mid bias");
	a_batt_off: assert property (BATTERY_UV |=> XCVR_STATE == XS_OFF && BUS_BIAS == BIAS_FLOAT)
		else $error("battery low but transceiver not off");
	a_tx_silenced: assert property (!TRANSCEIVER_ACTIVE |-> !TX_DRIVE_DOMINANT)
		else $error("transmitter drives outside active");
	a_listen_sel: assert property (s_on ##0 TRANSCEIVER_MODE_SELECT == TMS_LISTEN |=> XCVR_STATE == XS_LISTEN)
		else $error("listen select not obeyed");
	a_txd_low_hold: assert property (s_on ##0 (XCVR_STATE != XS_ACTIVE && !TXD_IN) |=> XCVR_STATE != XS_ACTIVE)
		else $error("active entered with transmit input low");
	a_uv_blocks: assert property (CHIP_MODE_CONTROL == CHIP_NORMAL && TRANSCEIVER_MODE_SELECT == TMS_ACTIVE_UV && SUPPLY_BELOW_90 |=> XCVR_STATE != XS_ACTIVE)
		else $error("active kept with supply low");
	a_wake_pulse: assert property ($rose(CHIP_WAKE_REQ) |-> s_req_pulse)
		else $error("wake request not a single paired pulse");
	a_wake_rxd: assert property ($rose(BUS_WAKE_EVENT) |-> !RXD_OUT)
		else $error("receive output high at wake");
endmodule : ctm_checker
bind ctm_top ctm_checker ctm_checker_inst (.CLK, .RSTN, .CHIP_MODE_CONTROL,
	.TRANSCEIVER_MODE_SELECT, .SUPPLY_BELOW_90, .BATTERY_UV, .TXD_IN, .TX_DRIVE_DOMINANT,
	.RXD_OUT, .BUS_BIAS, .TRANSCEIVER_ACTIVE, .BUS_WAKE_EVENT, .SUPPLY_ENABLE_REQ,
	.CHIP_WAKE_REQ, .XCVR_STATE);
`default_nettype wire

// [bench/ctm_ctrl_model.sv]
// controller-side model: drives the transmit pin and puts a wake pattern on the bus
`default_nettype none
module ctm_ctrl_model (
	input  wire logic clk,
	input  wire logic tx_bit,
	input  wire logic wake_go,
	input  wire logic bus_hold,
	output wire logic txd,
	output wire logic bus_dom
);
	timeunit 1ns;
	timeprecision 1ns;
	import ctm_pkg::*;
	localparam int D = WAKE_DOM_CYC + 10;
	localparam int R = WAKE_REC_CYC + 10;
	int   n    = 0;
	logic tx_r = 1'h1;
	always @(posedge clk) begin
		tx_r <= #2 tx_bit;
		n <= #2 (n == 0) ? int'(wake_go) : ((n == 2 * D + R) ? 0 : n + 1);
	end
	assign txd = tx_r;
	// dominant, recessive, dominant, each past its minimum
	assign bus_dom = bus_hold || (n != 0 && (n <= D || n > D + R));
endmodule : ctm_ctrl_model
`default_nettype wire

// [bench/ctm_top_tb_top.sv]
// self-checking bench for the transceiver mode controller
`default_nettype none
module ctm_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ctm_pkg::*;
	// chip mode, select, {supply low, battery low, transmit bit}, expected state
	localparam logic [12:0] ROWS [16] = '{
		{CHIP_NORMAL, 2'h1, 3'h1, XS_ACTIVE}, {CHIP_NORMAL, 2'h3, 3'h0, XS_LISTEN},
		{CHIP_NORMAL, 2'h1, 3'h0, XS_LISTEN}, {CHIP_NORMAL, 2'h1, 3'h5, XS_LISTEN},
		{CHIP_NORMAL, 2'h1, 3'h1, XS_ACTIVE}, {CHIP_NORMAL, 2'h1, 3'h5, XS_OFF_BIAS},
		{CHIP_NORMAL, 2'h2, 3'h5, XS_ACTIVE}, {CHIP_STANDBY, 2'h2, 3'h1, XS_OFFLINE},
		{CHIP_NORMAL, 2'h3, 3'h1, XS_LISTEN}, {CHIP_NORMAL, 2'h0, 3'h1, XS_OFFLINE},
		{CHIP_OFF, 2'h0, 3'h1, XS_OFF}, {CHIP_RESET, 2'h0, 3'h1, XS_OFFLINE},
		{CHIP_NORMAL, 2'h2, 3'h3, XS_OFF}, {CHIP_SLEEP, 2'h2, 3'h1, XS_OFFLINE},
		{CHIP_OVERTEMP, 2'h2, 3'h1, XS_OFF}, {CHIP_RESET, 2'h2, 3'h1, XS_OFFLINE}};
	// wake enable, selective enable, selective valid, wake expected
	localparam logic [3:0] WAKES [4] = '{4'hE, 4'h0, 4'hD, 4'hB};
	logic           clk = 1'h0, rstn = 1'h0, wclr = 1'h0, b90 = 1'h0, uv = 1'h0;
	logic           tx_bit = 1'h1, wake_go = 1'h0, bus_hold = 1'h0, brt = 1'h0;
	logic [1:0]     sel = 2'h0, bias;
	logic [2:0]     cfg = 3'h0;
	logic           txd, bus_dom, tx_dom, rxd, act, silent, wev, wake_req;
	ctm_chip_mode_t chip = CHIP_NORMAL;
	ctm_xcvr_state_t st;
	int             err_count = 0, checked = 0, nreq = 0, i;
	always #50 clk = ~clk;
	// counted on the falling edge, away from the edge that launches the pulse
	always @(negedge clk) if (wake_req === 1'h1) nreq++;
	ctm_ctrl_model ctm_ctrl_model_inst (.clk, .tx_bit, .wake_go, .bus_hold, .txd, .bus_dom);
	ctm_top ctm_top_inst (.CLK(clk), .RSTN(rstn), .CHIP_MODE_CONTROL(chip),
		.TRANSCEIVER_MODE_SELECT(sel), .BUS_WAKE_ENABLE(cfg[2]), .SELECTIVE_WAKE_ENABLE(cfg[1]),
		.SELECTIVE_CONFIG_VALID(cfg[0]), .BUS_WAKE_EVENT_CLR(wclr), .SUPPLY_BELOW_90(b90),
		.SUPPLY_BELOW_RESET_THR(brt), .BATTERY_UV(uv), .TXD_IN(txd), .BUS_RX_DOMINANT(bus_dom),
		.TX_DRIVE_DOMINANT(tx_dom), .RXD_OUT(rxd), .BUS_BIAS(bias), .TRANSCEIVER_ACTIVE(act),
		.BUS_SILENT(silent), .BUS_WAKE_EVENT(wev), .SUPPLY_ENABLE_REQ(), .CHIP_WAKE_REQ(wake_req),
		.XCVR_STATE(st));
	task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	task automatic summarize;
		$display("errors %0d, checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	// hang guard: a state never reached ends the run as a failure
	task automatic wait_st(input ctm_xcvr_state_t s, input int lim);
		for (i = 0; i < lim && st !== s; i++)
			step(1);
		if (i == lim) begin
			err_count++;
			summarize;
		end
	endtask : wait_st
	initial begin
		step(4);
		chk(st, XS_OFF);
		chk(5'(bias), 5'(BIAS_FLOAT));
		chk({2'h0, act, wev, rxd}, 5'h1);
		rstn = 1'h1;
		for (int k = 0; k < 16; k++) begin
			chip = ctm_chip_mode_t'(ROWS[k][12:10]);
			sel = ROWS[k][9:8];
			{b90, uv, tx_bit} = ROWS[k][7:5];
			step(4);
			chk(st, ROWS[k][4:0]);
			chk(5'(act), 5'(ROWS[k][4:0] == XS_ACTIVE));
		end
		chip = CHIP_NORMAL;
		sel = TMS_ACTIVE_NOUV;
		wait_st(XS_ACTIVE, 20);
		b90 = 1'h1;
		step(4);
		chk(st, XS_ACTIVE);
		brt = 1'h1;
		step(4);
		chk(st, XS_OFFLINE);
		b90 = 1'h0;
		brt = 1'h0;
		step(4);
		chk(st, XS_ACTIVE);
		bus_hold = 1'h1;
		tx_bit = 1'h0;
		step(4);
		chk({3'h0, tx_dom, rxd}, 5'h2);
		bus_hold = 1'h0;
		tx_bit = 1'h1;
		chip = CHIP_SLEEP;
		step(4);
		chk(st, XS_OFF_BIAS);
		chk(5'(bias), 5'(BIAS_MID));
		wait_st(XS_OFFLINE, 12000);
		chk(5'(silent), 5'h1);
		for (int k = 0; k < 4; k++) begin
			cfg = WAKES[k][3:1];
			wait_st(XS_OFFLINE, 12000);
			wclr = 1'h1;
			step(1);
			wclr = 1'h0;
			nreq = 0;
			wake_go = 1'h1;
			step(1);
			wake_go = 1'h0;
			for (i = 0; i < 400 && wev !== 1'h1; i++)
				step(1);
			step(2);
			chk({3'h0, wev, WAKES[k][0] & rxd}, {3'h0, WAKES[k][0], 1'h0});
			chk(5'(nreq), 5'(WAKES[k][0]));
		end
		// reset in mid-run, with the wake flag still set
		wait_st(XS_OFFLINE, 12000);
		rstn = 1'h0;
		step(1);
		chk(st, XS_OFF);
		chk({3'h0, wev, rxd}, 5'h1);
		chk(5'(bias), 5'(BIAS_FLOAT));
		rstn = 1'h1;
		step(2);
		chk(st, XS_OFFLINE);
		chk(5'(bias), 5'(BIAS_GND));
		summarize;
	end
endmodule : ctm_top_tb_top
`default_nettype wire

// [design/ctm_pkg.sv]
// package for the can transceiver mode controller: encodings and timing constants
`default_nettype none
package ctm_pkg;
	// chip operating modes seen on the chip_mode_control input
	typedef enum logic [2:0] {
		CHIP_OFF      = 3'h0,
		CHIP_OVERTEMP = 3'h1,
		CHIP_RESET    = 3'h2,
		CHIP_STANDBY  = 3'h3,
		CHIP_SLEEP    = 3'h4,
		CHIP_NORMAL   = 3'h7
	} ctm_chip_mode_t;

	// transceiver_mode_select field, bits 1:0 of the control register at 20h
	localparam logic [7:0] CAN_CTRL_ADDR   = 8'h20;
	localparam logic [7:0] XCVR_STAT_ADDR  = 8'h22;
	localparam int         XCVR_ACTIVE_BIT = 7;
	localparam logic [1:0] TMS_OFFLINE     = 2'h0;
	localparam logic [1:0] TMS_ACTIVE_UV   = 2'h1;
	localparam logic [1:0] TMS_ACTIVE_NOUV = 2'h2;
	localparam logic [1:0] TMS_LISTEN      = 2'h3;

	// transceiver states, one-hot
	typedef enum logic [4:0] {
		XS_OFF       = 5'h01,
		XS_OFFLINE   = 5'h02,
		XS_OFF_BIAS  = 5'h04,
		XS_LISTEN    = 5'h08,
		XS_ACTIVE    = 5'h10
	} ctm_xcvr_state_t;

	// wake detector phases
	typedef enum logic [3:0] {
		WK_IDLE = 4'h1,
		WK_DOM1 = 4'h2,
		WK_REC  = 4'h4,
		WK_DOM2 = 4'h8
	} ctm_wake_state_t;

	// bus bias encodings
	localparam logic [1:0] BIAS_FLOAT = 2'h0;
	localparam logic [1:0] BIAS_GND   = 2'h1;
	localparam logic [1:0] BIAS_MID   = 2'h2;

	// timing: clock 10 MHz
	localparam int CLK_HZ            = 10_000_000;
	localparam int SILENCE_US        = 1000;
	localparam int WAKE_DOM_NS       = 5000;
	localparam int WAKE_REC_NS       = 5000;
	localparam int WAKE_WINDOW_US    = 1000;
	localparam int SILENCE_CYC       = SILENCE_US * (CLK_HZ / 1_000_000);
	localparam int WAKE_DOM_CYC      = (WAKE_DOM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int WAKE_REC_CYC      = (WAKE_REC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int WAKE_WINDOW_CYC   = WAKE_WINDOW_US * (CLK_HZ / 1_000_000);
	localparam int CNT_W             = 16;
endpackage : ctm_pkg
`default_nettype wire

// [design/ctm_top.sv]
// can transceiver mode controller with standard wake-up pattern detection
`default_nettype none
module ctm_top (
	input  wire logic                CLK,
	input  wire logic                RSTN,
	input  wire ctm_pkg::ctm_chip_mode_t CHIP_MODE_CONTROL,
	input  wire logic [1:0]          TRANSCEIVER_MODE_SELECT,
	input  wire logic                BUS_WAKE_ENABLE,
	input  wire logic                SELECTIVE_WAKE_ENABLE,
	input  wire logic                SELECTIVE_CONFIG_VALID,
	input  wire logic                BUS_WAKE_EVENT_CLR,
	input  wire logic                SUPPLY_BELOW_90,
	input  wire logic                SUPPLY_BELOW_RESET_THR,
	input  wire logic                BATTERY_UV,
	input  wire logic                TXD_IN,
	input  wire logic                BUS_RX_DOMINANT,
	output logic                     TX_DRIVE_DOMINANT,
	output logic                     RXD_OUT,
	output logic [1:0]               BUS_BIAS,
	output logic                     TRANSCEIVER_ACTIVE,
	output logic                     BUS_SILENT,
	output logic                     BUS_WAKE_EVENT,
	output logic                     SUPPLY_ENABLE_REQ,
	output logic                     CHIP_WAKE_REQ,
	output ctm_pkg::ctm_xcvr_state_t XCVR_STATE
);
	import ctm_pkg::*;

	ctm_xcvr_state_t state_r, state_nxt;
	ctm_wake_state_t wk_r;
	ctm_chip_mode_t  mode_prev_r;
	logic [CNT_W-1:0] silence_cnt_r;
	logic [CNT_W-1:0] phase_cnt_r;
	logic [CNT_W-1:0] window_cnt_r;
	logic             rx_prev_r;
	logic             bus_silent_r;
	logic             wake_hit;
	logic             normal;
	logic             sel_active;
	logic             supply_ok;
	logic             chip_down;
	logic             watch_wake;
	logic             bus_edge;
	logic             sel_uv;

	assign normal     = (CHIP_MODE_CONTROL == CHIP_NORMAL);
	assign sel_uv     = (TRANSCEIVER_MODE_SELECT == TMS_ACTIVE_UV);
	assign sel_active = (TRANSCEIVER_MODE_SELECT == TMS_ACTIVE_UV) ||
	                    (TRANSCEIVER_MODE_SELECT == TMS_ACTIVE_NOUV);
	// 01 checks the 90 % level; 10 relies on the chip reset below its own threshold
	assign supply_ok  = (TRANSCEIVER_MODE_SELECT == TMS_ACTIVE_UV) ? !SUPPLY_BELOW_90
	                    : !SUPPLY_BELOW_RESET_THR;
	assign chip_down  = (CHIP_MODE_CONTROL == CHIP_OFF) ||
	                    (CHIP_MODE_CONTROL == CHIP_OVERTEMP) || BATTERY_UV;
	assign bus_edge   = (BUS_RX_DOMINANT != rx_prev_r);
	// offline bias is offline with mid-level bias; the pattern's first edge lands there
	assign watch_wake = ((state_r == XS_OFFLINE) || (state_r == XS_OFF_BIAS)) &&
	                    BUS_WAKE_ENABLE &&
	                    (!SELECTIVE_WAKE_ENABLE || !SELECTIVE_CONFIG_VALID);

	// previous bus level; resets to recessive, the idle level, so no false edge
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_prev_r <= 1'b0;
		end else begin
			rx_prev_r <= BUS_RX_DOMINANT;
		end
	end

	// silence timeout: any bus edge restarts it
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			silence_cnt_r <= '0;
			bus_silent_r  <= 1'b1;
		end else begin
			if (bus_edge) begin
				silence_cnt_r <= '0;
				bus_silent_r  <= 1'b0;
			end else if (silence_cnt_r >= CNT_W'(SILENCE_CYC)) begin
				bus_silent_r  <= 1'b1;
			end else begin
				silence_cnt_r <= silence_cnt_r + 1'b1;
			end
		end
	end

	// transceiver state selection
	always_comb begin
		state_nxt = state_r;
		if (chip_down) begin
			state_nxt = XS_OFF;
		end else if (state_r == XS_OFF) begin
			state_nxt = XS_OFFLINE;
		end else if (normal && sel_active) begin
			// once active, a dominant transmit bit is traffic, not a stuck pin
			if (supply_ok && (TXD_IN || state_r == XS_ACTIVE)) begin
				state_nxt = XS_ACTIVE;
			end else if (state_r == XS_ACTIVE) begin
				// supply below the check that the select field applies
				state_nxt = bus_silent_r ? XS_OFFLINE : XS_OFF_BIAS;
			end else if (!TXD_IN && state_r != XS_OFFLINE && state_r != XS_OFF_BIAS) begin
				state_nxt = XS_LISTEN;
			end else if (state_r == XS_LISTEN) begin
				state_nxt = XS_LISTEN;
			end else if (!TXD_IN) begin
				state_nxt = XS_LISTEN;
			end else if (state_r == XS_OFFLINE) begin
				// select 01 with a low supply asks for bias; otherwise bus activity decides
				if (sel_uv || wake_hit || bus_edge) begin
					state_nxt = XS_OFF_BIAS;
				end else begin
					state_nxt = XS_OFFLINE;
				end
			end else if (sel_uv) begin
				// keeping bias avoids toggling with offline every cycle
				state_nxt = XS_OFF_BIAS;
			end else begin
				state_nxt = bus_silent_r ? XS_OFFLINE : XS_OFF_BIAS;
			end
		end else if (normal && TRANSCEIVER_MODE_SELECT == TMS_LISTEN) begin
			state_nxt = XS_LISTEN;
		end else begin
			// select 00, reset, standby or sleep: offline states by bus activity
			case (state_r)
				XS_ACTIVE, XS_LISTEN: state_nxt = bus_silent_r ? XS_OFFLINE : XS_OFF_BIAS;
				XS_OFF_BIAS: state_nxt = bus_silent_r ? XS_OFFLINE : XS_OFF_BIAS;
				XS_OFFLINE: state_nxt = (wake_hit || bus_edge) ? XS_OFF_BIAS : XS_OFFLINE;
				default: state_nxt = XS_OFFLINE;
			endcase
		end
	end

	// chip mode of the previous cycle, for the power-up entry into offline
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_prev_r <= CHIP_OFF;
		end else begin
			mode_prev_r <= CHIP_MODE_CONTROL;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= XS_OFF;
		end else begin
			// leaving off/overtemp into reset lands offline unless the battery is low
			if (!chip_down && CHIP_MODE_CONTROL == CHIP_RESET &&
			    (mode_prev_r == CHIP_OFF || mode_prev_r == CHIP_OVERTEMP)) begin
				state_r <= XS_OFFLINE;
			end else begin
				state_r <= state_nxt;
			end
		end
	end

	// wake pattern detector: dominant, recessive, dominant inside the window
	assign wake_hit = watch_wake && (wk_r == WK_DOM2) && BUS_RX_DOMINANT &&
	                  (phase_cnt_r >= CNT_W'(WAKE_DOM_CYC - 1));

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wk_r         <= WK_IDLE;
			phase_cnt_r  <= '0;
			window_cnt_r <= '0;
		end else if (!watch_wake || wake_hit) begin
			wk_r         <= WK_IDLE;
			phase_cnt_r  <= '0;
			window_cnt_r <= '0;
		end else begin
			window_cnt_r <= (wk_r == WK_IDLE) ? '0 : window_cnt_r + 1'b1;
			case (wk_r)
				WK_IDLE: begin
					wk_r        <= BUS_RX_DOMINANT ? WK_DOM1 : WK_IDLE;
					phase_cnt_r <= '0;
				end
				WK_DOM1: begin
					// short glitches in a phase only restart that phase's count
					if (BUS_RX_DOMINANT) begin
						phase_cnt_r <= phase_cnt_r + 1'b1;
					end else if (phase_cnt_r >= CNT_W'(WAKE_DOM_CYC)) begin
						wk_r        <= WK_REC;
						phase_cnt_r <= '0;
					end else begin
						phase_cnt_r <= '0;
					end
				end
				WK_REC: begin
					if (!BUS_RX_DOMINANT) begin
						phase_cnt_r <= phase_cnt_r + 1'b1;
					end else if (phase_cnt_r >= CNT_W'(WAKE_REC_CYC)) begin
						wk_r        <= WK_DOM2;
						phase_cnt_r <= '0;
					end else begin
						phase_cnt_r <= '0;
					end
				end
				WK_DOM2: begin
					phase_cnt_r <= BUS_RX_DOMINANT ? phase_cnt_r + 1'b1 : '0;
				end
				default: wk_r <= WK_IDLE;
			endcase
			if (wk_r != WK_IDLE && window_cnt_r >= CNT_W'(WAKE_WINDOW_CYC)) begin
				wk_r         <= WK_IDLE;
				phase_cnt_r  <= '0;
				window_cnt_r <= '0;
			end
		end
	end

	// wake event flag; a new wake beats a clear in the same cycle
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			BUS_WAKE_EVENT <= 1'b0;
		end else if (wake_hit) begin
			BUS_WAKE_EVENT <= 1'b1;
		end else if (BUS_WAKE_EVENT_CLR) begin
			BUS_WAKE_EVENT <= 1'b0;
		end
	end

	// wake while asleep: one-cycle requests for the supply and the chip mode
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			CHIP_WAKE_REQ     <= 1'b0;
			SUPPLY_ENABLE_REQ <= 1'b0;
		end else begin
			CHIP_WAKE_REQ     <= wake_hit && (CHIP_MODE_CONTROL == CHIP_SLEEP);
			SUPPLY_ENABLE_REQ <= wake_hit && (CHIP_MODE_CONTROL == CHIP_SLEEP);
		end
	end

	// state mirror and active flag registered from the next state; silent flag from the silence timer
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			XCVR_STATE         <= XS_OFF;
			TRANSCEIVER_ACTIVE <= 1'b0;
			BUS_SILENT         <= 1'b1;
		end else begin
			XCVR_STATE         <= state_nxt;
			TRANSCEIVER_ACTIVE <= (state_nxt == XS_ACTIVE);
			BUS_SILENT         <= bus_silent_r;
		end
	end

	// transmit path: only active drives the bus
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			TX_DRIVE_DOMINANT <= 1'b0;
		end else begin
			TX_DRIVE_DOMINANT <= (state_nxt == XS_ACTIVE) && !TXD_IN;
		end
	end

	// receive path: bus data while online, held low after a wake
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			RXD_OUT <= 1'b1;
		end else if (state_nxt == XS_ACTIVE || state_nxt == XS_LISTEN) begin
			RXD_OUT <= !BUS_RX_DOMINANT;
		end else if (wake_hit || BUS_WAKE_EVENT) begin
			RXD_OUT <= 1'b0;
		end else begin
			RXD_OUT <= 1'b1;
		end
	end

	// bus bias follows the next state
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			BUS_BIAS <= BIAS_FLOAT;
		end else begin
			case (state_nxt)
				XS_ACTIVE, XS_LISTEN, XS_OFF_BIAS: BUS_BIAS <= BIAS_MID;
				XS_OFFLINE: BUS_BIAS <= BIAS_GND;
				default: BUS_BIAS <= BIAS_FLOAT;
			endcase
		end
	end
endmodule : ctm_top
`default_nettype wire
